// file: bps_pkg.sv
package bps_pkg;
  // Clock and timing.
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned OC_TIME_NS = 50000;
  localparam int unsigned OC_CYC =
    (OC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SS_STEP_NS = 1000;
  localparam int unsigned SS_CYC =
    (SS_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RD_STEP_NS = 5000;
  localparam int unsigned RD_CYC =
    (RD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Voltage thresholds in millivolts, one code per millivolt.
  localparam int unsigned UV_MARGIN_MV = 300;
  localparam int unsigned OV_MARGIN_MV = 400;
  localparam int unsigned OV_RELEASE_MV = 100;
  localparam int unsigned OV_START_MV = 2900;

  // Reference DAC.
  localparam int unsigned DAC_RESET_MV = 0;
  localparam int unsigned DAC_STEP_MV = 1;

  typedef enum logic [2:0] {
    BPS_OFF,
    BPS_RAMP,
    BPS_RUN,
    BPS_OCP,
    BPS_OVP
  } bps_state_t;
endpackage

// file: bps_protect.sv
`timescale 1ns/1ps
// Function
// - Soft-start steps DAC up at fixed rate
// - Any low supply holds off switching
// - Sensed current above reference flags over-current
// - Over-current persisting 50 us shuts down
// - 150 percent load shuts down immediately
// - Over-current latch kept until supply/enable toggle
// - Output 300 mV under DAC-droop drops ready
// - Overvoltage in run drops ready, ramps DAC down
// - Overvoltage clamps low side until 100 mV
// - Overvoltage latch kept until supply/enable toggle
// - Start-up uses fixed absolute overvoltage threshold
module bps_protect #(
  parameter int DW = 12,
  parameter int OV_START = bps_pkg::OV_START_MV
) (
  input wire logic clk_sys, // System clock, 50 MHz.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic enable, // Converter enable.
  input wire logic shunt_supply_ok, // Shunt supply above lockout.
  input wire logic driver_supply_ok, // Gate driver supply above lockout.
  input wire logic bootstrap_supply_ok, // Bootstrap above lockout.
  input wire logic over_limit_100, // Sense current above reference.
  input wire logic over_limit_150, // Sense current above 150 percent.
  input wire logic [DW-1:0] vout_mv, // Sensed output voltage.
  input wire logic [DW-1:0] droop_mv, // Droop voltage.
  input wire logic [DW-1:0] target_mv, // Target reference voltage.
  output logic [DW-1:0] dac_mv_q, // Reference DAC code.
  output logic switch_en_q, // Switching permitted.
  output logic hs_allow_q, // High-side driver may follow PWM.
  output logic ls_clamp_q, // Low-side driver forced on.
  output logic regulator_ready_flag_q, // Output regulating.
  output logic ready_pin_out_q, // Ready pin drive level.
  output logic ready_pin_oe_q, // Ready pin pulled low.
  output logic oc_fault_q, // Over-current latch.
  output logic ov_fault_q, // Overvoltage latch.
  output logic lockout_q // Supply lockout active.
);

  localparam int OCW = $clog2(bps_pkg::OC_CYC + 1);
  localparam int SSW = $clog2(bps_pkg::SS_CYC + 1);
  localparam int RDW = $clog2(bps_pkg::RD_CYC + 1);

  if (DW < 12 || DW > 16) begin : g_dw_bad
    $error("DW must lie between 12 and 16.");
  end
  if (OV_START >= (1 << DW)) begin : g_ov_start_bad
    $error("OV_START does not fit the voltage width.");
  end

  function automatic logic [DW:0] ext(input logic [DW-1:0] v);
    ext = {1'b0, v};
  endfunction

  function automatic logic [DW-1:0] sat_sub(input logic [DW-1:0] a,
                                            input logic [DW-1:0] b);
    sat_sub = (a > b) ? a - b : '0;
  endfunction

  function automatic logic is_live(input bps_pkg::bps_state_t s);
    is_live = (s == bps_pkg::BPS_RAMP) || (s == bps_pkg::BPS_RUN);
  endfunction

  bps_pkg::bps_state_t state_q;
  bps_pkg::bps_state_t state_d;
  logic [OCW-1:0] oc_cnt_q;
  logic [SSW-1:0] ss_cnt_q;
  logic [RDW-1:0] rd_cnt_q;
  logic supply_ok;
  logic active;
  logic ss_tick;
  logic rd_tick;
  logic oc_trip;
  logic uv_trip;
  logic ov_run;
  logic ov_start;
  logic ov_release;

  assign supply_ok = shunt_supply_ok && driver_supply_ok &&
                     bootstrap_supply_ok;
  assign active = is_live(state_q);
  assign ss_tick = (ss_cnt_q == SSW'(bps_pkg::SS_CYC - 1));
  assign rd_tick = (rd_cnt_q == RDW'(bps_pkg::RD_CYC - 1));
  // The trip fires on the cycle that completes the full persistence span.
  assign oc_trip = over_limit_100 &&
                   (oc_cnt_q == OCW'(bps_pkg::OC_CYC - 1));
  assign uv_trip = (ext(vout_mv) + (DW+1)'(bps_pkg::UV_MARGIN_MV)) <
                   ext(sat_sub(dac_mv_q, droop_mv));
  assign ov_run = ext(vout_mv) >
                  (ext(dac_mv_q) + (DW+1)'(bps_pkg::OV_MARGIN_MV));
  assign ov_start = ext(vout_mv) > (DW+1)'(OV_START);
  assign ov_release = ext(vout_mv) <=
                      (DW+1)'(bps_pkg::OV_RELEASE_MV);

  always_comb begin
    state_d = state_q;
    case (state_q)
      bps_pkg::BPS_OFF: begin
        state_d = bps_pkg::BPS_RAMP;
      end
      bps_pkg::BPS_RAMP: begin
        if (over_limit_150 || oc_trip) begin
          state_d = bps_pkg::BPS_OCP;
        end else if (ov_start) begin
          state_d = bps_pkg::BPS_OVP;
        end else if (dac_mv_q >= target_mv) begin
          state_d = bps_pkg::BPS_RUN;
        end
      end
      bps_pkg::BPS_RUN: begin
        if (over_limit_150 || oc_trip) begin
          state_d = bps_pkg::BPS_OCP;
        end else if (ov_run) begin
          state_d = bps_pkg::BPS_OVP;
        end
      end
      bps_pkg::BPS_OCP: begin
        state_d = bps_pkg::BPS_OCP;
      end
      bps_pkg::BPS_OVP: begin
        state_d = bps_pkg::BPS_OVP;
      end
      default: begin
        state_d = bps_pkg::BPS_OFF;
      end
    endcase
    // A supply dip or enable toggle is the only way out of a latch.
    if (!enable || !supply_ok) begin
      state_d = bps_pkg::BPS_OFF;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= bps_pkg::BPS_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      oc_cnt_q <= '0;
    end else if (active && over_limit_100 && !oc_trip) begin
      oc_cnt_q <= oc_cnt_q + OCW'(1);
    end else begin
      oc_cnt_q <= '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ss_cnt_q <= '0;
      rd_cnt_q <= '0;
    end else begin
      ss_cnt_q <= ss_tick ? '0 : ss_cnt_q + SSW'(1);
      rd_cnt_q <= rd_tick ? '0 : rd_cnt_q + RDW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dac_mv_q <= DW'(bps_pkg::DAC_RESET_MV);
    end else begin
      case (state_d)
        bps_pkg::BPS_RAMP, bps_pkg::BPS_RUN: begin
          if (ss_tick && dac_mv_q < target_mv) begin
            dac_mv_q <= dac_mv_q + DW'(bps_pkg::DAC_STEP_MV);
          end else if (ss_tick && dac_mv_q > target_mv) begin
            dac_mv_q <= dac_mv_q - DW'(bps_pkg::DAC_STEP_MV);
          end
        end
        bps_pkg::BPS_OVP: begin
          if (rd_tick && dac_mv_q != '0) begin
            dac_mv_q <= dac_mv_q - DW'(bps_pkg::DAC_STEP_MV);
          end
        end
        bps_pkg::BPS_OCP: begin
          dac_mv_q <= dac_mv_q;
        end
        default: begin
          dac_mv_q <= DW'(bps_pkg::DAC_RESET_MV);
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      switch_en_q <= 1'b0;
      hs_allow_q <= 1'b0;
      ls_clamp_q <= 1'b0;
      lockout_q <= 1'b1;
    end else begin
      switch_en_q <= is_live(state_d);
      hs_allow_q <= is_live(state_d);
      ls_clamp_q <= (state_d == bps_pkg::BPS_OVP) &&
                    ((state_q != bps_pkg::BPS_OVP) ||
                     (ls_clamp_q && !ov_release));
      lockout_q <= !supply_ok;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      regulator_ready_flag_q <= 1'b0;
      ready_pin_out_q <= 1'b0;
      ready_pin_oe_q <= 1'b1;
    end else begin
      regulator_ready_flag_q <= (state_d == bps_pkg::BPS_RUN) &&
                                !uv_trip && !ov_run;
      ready_pin_out_q <= 1'b0;
      ready_pin_oe_q <= !((state_d == bps_pkg::BPS_RUN) &&
                          !uv_trip && !ov_run);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      oc_fault_q <= 1'b0;
      ov_fault_q <= 1'b0;
    end else begin
      oc_fault_q <= (state_d == bps_pkg::BPS_OCP);
      ov_fault_q <= (state_d == bps_pkg::BPS_OVP);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_run_kept;
    state_q == bps_pkg::BPS_RAMP && state_d != bps_pkg::BPS_OFF;
  endsequence

  sequence s_ov_entry;
    ov_fault_q && !$past(ov_fault_q);
  endsequence

  property p_ss_step;
    s_run_kept ##0 (state_d == bps_pkg::BPS_RAMP && ss_tick &&
                    dac_mv_q < target_mv)
    |=> dac_mv_q == $past(dac_mv_q) + DW'(1);
  endproperty
  a_ss_step: assert property (p_ss_step)
    else $error("Soft-start did not advance one step.");

  property p_lockout;
    !supply_ok |=> !switch_en_q && !hs_allow_q && lockout_q;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("Switching allowed with a supply low.");

  property p_oc_count;
    active && state_d == state_q && over_limit_100 && !oc_trip
    |=> oc_cnt_q == $past(oc_cnt_q) + OCW'(1);
  endproperty
  a_oc_count: assert property (p_oc_count)
    else $error("Over-current timer did not advance.");

  property p_oc_cause;
    $rose(oc_fault_q) |-> $past(over_limit_150) ||
      ($past(over_limit_100) &&
       $past(oc_cnt_q) == OCW'(bps_pkg::OC_CYC - 1));
  endproperty
  a_oc_cause: assert property (p_oc_cause)
    else $error("Over-current shutdown before the persistence time.");

  property p_oc_fast;
    active && enable && supply_ok && over_limit_150
    |=> oc_fault_q && !hs_allow_q;
  endproperty
  a_oc_fast: assert property (p_oc_fast)
    else $error("Heavy over-current did not shut down at once.");

  property p_oc_hold;
    oc_fault_q && enable && supply_ok |=> oc_fault_q && !switch_en_q;
  endproperty
  a_oc_hold: assert property (p_oc_hold)
    else $error("Over-current latch released without a toggle.");

  property p_uv_ready;
    state_d == bps_pkg::BPS_RUN && uv_trip
    |=> !regulator_ready_flag_q && ready_pin_oe_q;
  endproperty
  a_uv_ready: assert property (p_uv_ready)
    else $error("Ready stayed high under output undervoltage.");

  property p_ov_trip;
    state_q == bps_pkg::BPS_RUN && enable && supply_ok && ov_run &&
    !over_limit_150 && !oc_trip
    |=> ov_fault_q && !regulator_ready_flag_q;
  endproperty
  a_ov_trip: assert property (p_ov_trip)
    else $error("Overvoltage did not trip from normal operation.");

  property p_ov_ramp_down;
    state_q == bps_pkg::BPS_OVP && state_d == bps_pkg::BPS_OVP &&
    rd_tick && dac_mv_q != '0
    |=> dac_mv_q == $past(dac_mv_q) - DW'(1);
  endproperty
  a_ov_ramp_down: assert property (p_ov_ramp_down)
    else $error("DAC did not ramp down during overvoltage.");

  property p_ov_clamp;
    s_ov_entry |-> ls_clamp_q && !hs_allow_q;
  endproperty
  a_ov_clamp: assert property (p_ov_clamp)
    else $error("Low side not clamped on overvoltage entry.");

  property p_ov_hold;
    ov_fault_q && enable && supply_ok |=> ov_fault_q && !hs_allow_q;
  endproperty
  a_ov_hold: assert property (p_ov_hold)
    else $error("Overvoltage latch released without a toggle.");

  property p_start_thresh;
    state_q == bps_pkg::BPS_RAMP && !ov_start |=> !ov_fault_q;
  endproperty
  a_start_thresh: assert property (p_start_thresh)
    else $error("Start-up overvoltage below the fixed threshold.");

  property p_disable;
    !enable |=> state_q == bps_pkg::BPS_OFF && dac_mv_q == '0 &&
                !oc_fault_q && !ov_fault_q;
  endproperty
  a_disable: assert property (p_disable)
    else $error("Enable low did not clear the block.");

endmodule

// file: bps_stage_model.sv
`timescale 1ns/1ps
module bps_stage_model (
  input wire logic clk_sys, // System clock.
  input wire logic rst_b, // Reset, active low.
  input wire logic hs_allow, // High side follows PWM.
  input wire logic ls_clamp, // Low side forced on.
  input wire logic [11:0] dac_mv, // Reference the loop settles to.
  input wire logic ovr_en, // Disturbance forces the output.
  input wire logic [11:0] ovr_mv, // Forced output level.
  output logic [11:0] vout_mv // Sensed output.
);
  logic [11:0] lvl_q;
  // A clamped low side drains the output fast; a floating one leaks slowly.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lvl_q <= 12'h000;
    end else if (ls_clamp) begin
      lvl_q <= (lvl_q > 12'h00a) ? lvl_q - 12'h00a : 12'h000;
    end else if (hs_allow) begin
      lvl_q <= dac_mv;
    end else if (lvl_q != 12'h000) begin
      lvl_q <= lvl_q - 12'h001;
    end
  end
  assign vout_mv = ovr_en ? ovr_mv : lvl_q;
endmodule

// file: test_buck_protection_softstart.sv
`timescale 1ns/1ps
module test_buck_protection_softstart;
  logic clk_sys, rst_b, enable, sh_ok, dr_ok, bs_ok, ol100, ol150;
  logic ovr_en, sw, hs, ls, rdy, pin_out, pin_oe, oc, ov, lock;
  logic [11:0] vout, droop, target, ovr_mv, dac, p;
  logic [4:0] rows [8] = '{5'h1d, 5'h0e, 5'h1d, 5'h16, 5'h1d, 5'h1a,
    5'h02, 5'h1d};
  logic [35:0] uv [4] = '{36'h000064068, 36'h000063064, 36'h032032068,
    36'h032031064};
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  wire [6:0] fl = {sw, hs, ls, rdy, pin_oe, oc, ov};

  bps_protect uut (.clk_sys(clk_sys), .rst_b(rst_b), .enable(enable),
    .shunt_supply_ok(sh_ok), .driver_supply_ok(dr_ok),
    .bootstrap_supply_ok(bs_ok), .over_limit_100(ol100),
    .over_limit_150(ol150), .vout_mv(vout), .droop_mv(droop),
    .target_mv(target), .dac_mv_q(dac), .switch_en_q(sw),
    .hs_allow_q(hs), .ls_clamp_q(ls), .regulator_ready_flag_q(rdy),
    .ready_pin_out_q(pin_out), .ready_pin_oe_q(pin_oe),
    .oc_fault_q(oc), .ov_fault_q(ov), .lockout_q(lock));
  bps_stage_model stage (.clk_sys(clk_sys), .rst_b(rst_b),
    .hs_allow(hs), .ls_clamp(ls), .dac_mv(dac), .ovr_en(ovr_en),
    .ovr_mv(ovr_mv), .vout_mv(vout));

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask

  task automatic chk(input string nm, input logic [11:0] s,
      input logic [11:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic restart();
    enable = 1'h0;
    cyc(2);
    chk("off_dac", dac, 12'h000);
    chk("off_flags", 12'(fl), 12'h004);
    enable = 1'h1;
    cyc(2);
    chk("on_flags", 12'(fl), 12'h064);
  endtask

  task automatic hold(input int k);
    ol100 = 1'h1;
    cyc(k);
    ol100 = 1'h0;
    cyc(1);
  endtask

  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    {rst_b, enable, ol100, ol150, ovr_en} = 5'h00;
    {sh_ok, dr_ok, bs_ok} = 3'h7;
    droop = 12'h000;
    target = 12'h190;
    ovr_mv = 12'h000;
    cyc(8);
    chk("rst_flags", 12'(fl), 12'h004);
    chk("rst_lock", 12'(lock), 12'h001);
    chk("rst_dac", dac, 12'h000);
    rst_b = 1'h1;
    enable = 1'h1;
    for (int i = 0; i < 8; i++) begin
      {sh_ok, dr_ok, bs_ok} = rows[i][4:2];
      cyc(2);
      chk("lockout", 12'(lock), 12'(rows[i][1]));
      chk("switch", 12'(sw), 12'(rows[i][0]));
    end
    // Far above the DAC-relative level, yet start-up must not trip.
    ovr_en = 1'h1;
    ovr_mv = 12'hb54;
    cyc(3);
    chk("ov_start_hold", 12'(fl), 12'h064);
    ovr_mv = 12'hb55;
    cyc(2);
    chk("ov_start_trip", 12'(fl), 12'h015);
    ovr_en = 1'h0;
    cyc(3);
    chk("ov_latched", 12'(fl), 12'h005);
    restart();
    hold(2499);
    hold(2499);
    chk("oc_short", 12'(fl), 12'h064);
    ol100 = 1'h1;
    cyc(2499);
    chk("oc_early", 12'(fl), 12'h064);
    cyc(1);
    ol100 = 1'h0;
    chk("oc_trip", 12'(fl), 12'h006);
    cyc(50);
    chk("oc_latched", 12'(fl), 12'h006);
    dr_ok = 1'h0;
    cyc(2);
    dr_ok = 1'h1;
    cyc(2);
    chk("oc_supply", 12'(fl), 12'h064);
    ol150 = 1'h1;
    cyc(1);
    chk("oc_fast", 12'(fl), 12'h006);
    ol150 = 1'h0;
    cyc(1);
    chk("oc_fast_hold", 12'(fl), 12'h006);
    restart();
    p = dac;
    n = 0;
    while (rdy !== 1'h1 && n < 21000) begin
      cyc(1);
      n++;
      chk("ramp_step", 12'(dac == p || dac == p + 12'h001), 12'h001);
      p = dac;
    end
    chk("ramp_time", 12'(n >= 399 * bps_pkg::SS_CYC - 2 &&
      n <= 400 * bps_pkg::SS_CYC + 4), 12'h001);
    chk("ramp_end", dac, target);
    chk("run", 12'(fl), 12'h068);
    chk("pin_level", 12'(pin_out), 12'h000);
    target = 12'h18f;
    cyc(bps_pkg::SS_CYC + 1);
    chk("track_down", dac, 12'h18f);
    target = 12'h190;
    cyc(bps_pkg::SS_CYC + 1);
    chk("track_up", dac, 12'h190);
    ovr_en = 1'h1;
    foreach (uv[i]) begin
      {droop, ovr_mv} = uv[i][35:12];
      cyc(2);
      chk("uv", 12'(fl), uv[i][11:0]);
    end
    droop = 12'h000;
    ovr_mv = 12'h320;
    cyc(2);
    chk("ov_edge", 12'(fl), 12'h068);
    ovr_mv = 12'h321;
    cyc(2);
    chk("ov_trip", 12'(fl), 12'h015);
    chk("ov_slow", 12'(dac >= 12'h18f), 12'h001);
    ovr_en = 1'h0;
    cyc(bps_pkg::RD_CYC + 2);
    chk("ov_release", 12'(fl), 12'h005);
    chk("ov_ramp_down", 12'(dac < target), 12'h001);
    restart();
    final_report();
  end
endmodule
